/* File: logic/itd_consts.vh */
`ifndef ITD_CONSTS_VH
`define ITD_CONSTS_VH

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define ITD_IW_W          14
`define ITD_F_LSB         0
`define ITD_F_W           7
`define ITD_D_BIT         7
`define ITD_B_LSB         7
`define ITD_B_W           3
`define ITD_N_BIT         2
`define ITD_MM_LSB        0
`define ITD_MM_W          2
`define ITD_IND0_ADDR     7'h00
`define ITD_IND1_ADDR     7'h01
`define ITD_PTR_W         16
`define ITD_PTR_MSB       15

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ITD_OSC_PER_CYC   4
`define ITD_PH_W          2

// ----------------------------------------------------------------
// Pointer step modes
// ----------------------------------------------------------------
`define ITD_MM_PREINC     2'h0
`define ITD_MM_PREDEC     2'h1
`define ITD_MM_POSTINC    2'h2
`define ITD_MM_POSTDEC    2'h3

// ----------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------
`define ITD_C_BYTE        4'h0
`define ITD_C_BIT         4'h1
`define ITD_C_LIT         4'h2
`define ITD_C_CALL        4'h3
`define ITD_C_RET         4'h4
`define ITD_C_JUMP        4'h5
`define ITD_C_SKIP        4'h6
`define ITD_C_IND         4'h7
`define ITD_C_RSVD        4'hf

`endif

/* File: logic/itd_phase.v */
`timescale 1ns/1ns
`include "itd_consts.vh"

// ----------------------------------------------------------------
// Four-phase sequencer: one instruction cycle per four clocks.
// ----------------------------------------------------------------
module itd_phase (
    input  wire                   clock,
    input  wire                   nrst,
    input  wire                   ce,
    output reg  [`ITD_PH_W-1:0]   phase_q,
    output reg                    cyc_end_q
);

    // Phase counter wraps every four oscillator clocks.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_q   <= 2'h0;
            cyc_end_q <= 1'b0;
        end else if (ce) begin
            phase_q   <= phase_q + 2'h1;
            cyc_end_q <= (phase_q == 2'h2);
        end
    end

endmodule

/* File: logic/itd_top.v */
`timescale 1ns/1ns
`include "itd_consts.vh"

// Functional notes
// - Each instruction is one 14-bit word with opcode and all operands.
// - Instructions take one instruction cycle except listed multi-cycle kinds.
// - Direct call and call through accumulator take two cycles.
// - Plain return, literal return and interrupt exit take two cycles.
// - Jumps and taken skips take two cycles.
// - Indirect data access to program memory adds one cycle; the code stalls only for file ops on 0x00/0x01, never for indirect moves.
// - One instruction cycle is four oscillator clocks.
// - File register operands are read, modified, then written back.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - File address field is a 7-bit index, 0x00 to 0x7f.
// - Bit operand picks one of eight bits in a file register.
// - Don't-care instruction bits are ignored by decode.
// - Pointer number selects indirect pair zero or one.
// - Two-bit step_select picks pre/post increment or decrement.
// - Program counter change or true test adds a no-operation cycle.
// - Pointer msb set marks an indirect access as program memory.

// ----------------------------------------------------------------
// Instruction decode and cycle timing
// ----------------------------------------------------------------
module itd_top #(
    parameter IW = `ITD_IW_W
) (
    input  wire                    clock,
    input  wire                    nrst,
    input  wire                    ce,
    input  wire [IW-1:0]           instr,
    input  wire                    instr_valid,
    input  wire                    test_true,
    input  wire [`ITD_PTR_W-1:0]   ptr0,
    input  wire [`ITD_PTR_W-1:0]   ptr1,
    output reg                     fetch_q,
    output reg  [3:0]              iclass_q,
    output reg  [`ITD_F_W-1:0]     faddr_q,
    output reg  [2:0]              bitsel_q,
    output reg  [7:0]              bitmask_q,
    output reg                     dest_file_q,
    output reg                     rd_file_q,
    output reg                     wr_file_q,
    output reg                     wr_acc_q,
    output reg                     ptr_sel_q,
    output reg  [1:0]              step_select_q,
    output reg                     nop_cycle_q,
    output reg                     stall_cycle_q,
    output reg                     reserved_q,
    output reg  [1:0]              phase_q
);

    // ------------------------------------------------------------
    // Execution states, one-hot
    // ------------------------------------------------------------
    localparam [2:0] ST_EXEC  = 3'h1;
    localparam [2:0] ST_NOP   = 3'h2;
    localparam [2:0] ST_STALL = 3'h4;

    wire [1:0] ph;
    wire       cyc_end;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg  [IW-1:0] iw_q;
    reg  [3:0] cls;
    reg        wr_only;
    reg        ind_pm;
    reg        needs_nop;
    reg        is_file;
    reg        tst_only;
    wire [7:0] mask_d;

    itd_phase u_phase (
        .clock     (clock),
        .nrst      (nrst),
        .ce        (ce),
        .phase_q   (ph),
        .cyc_end_q (cyc_end)
    );

    // ------------------------------------------------------------
    // Opcode classification; x bits never feed the compare.
    // ------------------------------------------------------------
    function [3:0] classify;
        input [IW-1:0] w;
        begin
            classify = `ITD_C_RSVD;
            if (w[13:12] == 2'b00) begin
                if (w[11:8] == 4'b1011 || w[11:8] == 4'b1111)
                    classify = `ITD_C_SKIP;
                else if (w[11:8] != 4'b0000)
                    classify = `ITD_C_BYTE;
                else if (w[7])
                    classify = `ITD_C_BYTE;
                else if (w[7:0] == 8'h08 || w[7:0] == 8'h09 ||
                         w[7:0] == 8'h0b)
                    classify = `ITD_C_RET;
                else if (w[7:0] == 8'h0a || w[7:0] == 8'h0e)
                    classify = `ITD_C_CALL;
                else if (w[7:3] == 5'b00010)
                    classify = `ITD_C_IND;
                else if (w[7:0] == 8'h00)
                    classify = `ITD_C_LIT;
            end else if (w[13:12] == 2'b01) begin
                classify = w[11] ? `ITD_C_SKIP : `ITD_C_BIT;
            end else if (w[13:12] == 2'b10) begin
                classify = w[11] ? `ITD_C_JUMP : `ITD_C_CALL;
            end else begin
                if (w[11:10] == 2'b01)
                    classify = `ITD_C_RET;
                else if (w[11:9] == 3'b001)
                    classify = `ITD_C_JUMP;
                else
                    classify = `ITD_C_LIT;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // File-register operand test
    // ------------------------------------------------------------
    // Shared by the stall, read and write decodes so that the three
    // can never disagree. The accumulator clear sits in the byte
    // group but names no file register, so it neither reads nor
    // stalls.
    function file_op;
        input [3:0]    c;
        input [IW-1:0] w;
        begin
            file_op = (c == `ITD_C_BYTE || c == `ITD_C_BIT ||
                       c == `ITD_C_SKIP) &&
                      !(w[13:7] == 7'h02);
        end
    endfunction

    // ------------------------------------------------------------
    // One-hot bit mask
    // ------------------------------------------------------------
    // One comparator per bit lane keeps the mask free of a wide
    // shifter and makes each lane plainly one-hot.
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_mask
            assign mask_d[k] = (iw_q[`ITD_B_LSB +: `ITD_B_W] == k);
        end
    endgenerate

    // ------------------------------------------------------------
    // Decode limitations
    // ------------------------------------------------------------
    // Only the opcode groups that change timing or operand use are
    // told apart. Literal-class words all share one code, since
    // none of them touches a file register or changes the flow.
    // Patterns that match no listed group raise reserved_q and are
    // otherwise run as one-cycle no-ops; the core does not trap.
    // The pointer step operand is passed on untouched: the pointer
    // arithmetic itself lives in the datapath, not here.
    // The accumulator clear shares its upper bits with the file
    // clear, so the destination bit alone tells the two apart.
    // Bit-test skips only read their register and never store.

    // Decoded view of the word held in the current instruction cycle.
    always @* begin
        cls       = classify(iw_q);
        is_file   = file_op(cls, iw_q);
        tst_only  = (cls == `ITD_C_SKIP) && (iw_q[13:12] == 2'b01);
        wr_only   = ((iw_q[13:8] == 6'h00) || (iw_q[13:8] == 6'h01)) &&
                    iw_q[`ITD_D_BIT];
        ind_pm    = 1'b0;
        needs_nop = 1'b0;
        if (is_file) begin
            if (iw_q[6:0] == `ITD_IND0_ADDR)
                ind_pm = ptr0[`ITD_PTR_MSB];
            else if (iw_q[6:0] == `ITD_IND1_ADDR)
                ind_pm = ptr1[`ITD_PTR_MSB];
        end
        if (cls == `ITD_C_CALL || cls == `ITD_C_RET ||
            cls == `ITD_C_JUMP)
            needs_nop = 1'b1;
        else if (cls == `ITD_C_SKIP && test_true)
            needs_nop = 1'b1;
    end

    // ------------------------------------------------------------
    // Instruction-cycle walk
    // ------------------------------------------------------------
    // Each instruction cycle is four clocks, counted by the phase
    // sequencer. The word in iw_q is replaced only on the clock
    // that ends phase 3, and only when the next state is EXEC or NOP, so
    // every decode output below stands for one whole instruction
    // cycle. The file read strobe falls in phase 1 and the write
    // strobe in phase 3 so that a consumer always sees the old
    // value before the new one is stored.
    //
    // A word that touches an indirect data port whose pointer has
    // its top bit set goes EXEC, STALL, EXEC, costing one extra
    // cycle while the program-memory operand is fetched.
    // A call, return, jump or taken skip goes EXEC, NOP, EXEC;
    // the word is cleared to zero on entry to NOP so that the
    // no-op cycle decodes as a harmless literal class and drives
    // no strobes. When both apply, the stall comes first and the
    // no-op follows it, three cycles in all.
    //
    // The skip condition is a level from the datapath. It is read
    // in the last phase of the cycle, so the datapath has three
    // clocks to settle it after the read strobe.

    // Next state at each instruction-cycle boundary.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (ind_pm)
                    state_d = ST_STALL;
                else if (needs_nop)
                    state_d = ST_NOP;
            end
            ST_STALL: begin
                state_d = needs_nop ? ST_NOP : ST_EXEC;
            end
            ST_NOP: begin
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and registered outputs
    // ------------------------------------------------------------
    // The word is latched only when a new cycle starts in EXEC, so a
    // fetch arriving during a stall or no-op cycle is discarded.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q       <= ST_EXEC;
            iw_q          <= 14'h0000;
            fetch_q       <= 1'b0;
            iclass_q      <= `ITD_C_LIT;
            faddr_q       <= 7'h00;
            bitsel_q      <= 3'h0;
            bitmask_q     <= 8'h00;
            dest_file_q   <= 1'b0;
            rd_file_q     <= 1'b0;
            wr_file_q     <= 1'b0;
            wr_acc_q      <= 1'b0;
            ptr_sel_q     <= 1'b0;
            step_select_q <= 2'h0;
            nop_cycle_q   <= 1'b0;
            stall_cycle_q <= 1'b0;
            reserved_q    <= 1'b0;
            phase_q       <= 2'h0;
        end else if (ce) begin
            phase_q <= ph;
            fetch_q <= cyc_end && (state_d == ST_EXEC);
            if (cyc_end) begin
                state_q <= state_d;
                if (state_d == ST_EXEC && instr_valid)
                    iw_q <= instr;
                else if (state_d == ST_NOP)
                    iw_q <= 14'h0000;
            end
            nop_cycle_q   <= (state_q == ST_NOP);
            stall_cycle_q <= (state_q == ST_STALL);
            iclass_q      <= cls;
            reserved_q    <= (cls == `ITD_C_RSVD);
            faddr_q       <= iw_q[`ITD_F_LSB +: `ITD_F_W];
            bitsel_q      <= iw_q[`ITD_B_LSB +: `ITD_B_W];
            bitmask_q     <= mask_d;
            ptr_sel_q     <= iw_q[`ITD_N_BIT];
            step_select_q <= iw_q[`ITD_MM_LSB +: `ITD_MM_W];
            dest_file_q   <= iw_q[`ITD_D_BIT] | (cls == `ITD_C_BIT);
            // Read in phase 1, write in phase 3, even for write-only ops.
            rd_file_q <= (state_q == ST_EXEC) && (ph == 2'h0) &&
                         is_file;
            wr_file_q <= (state_q == ST_EXEC) && (ph == 2'h2) &&
                         is_file && !tst_only &&
                         ((cls == `ITD_C_BIT) ||
                          iw_q[`ITD_D_BIT] || wr_only);
            wr_acc_q  <= (state_q == ST_EXEC) && (ph == 2'h2) &&
                         (cls == `ITD_C_BYTE || cls == `ITD_C_SKIP) &&
                         !tst_only &&
                         !iw_q[`ITD_D_BIT] && !wr_only;
        end
    end

endmodule

/* File: sim/itd_monitor.sv */
`timescale 1ns/1ns
`include "itd_consts.vh"

// ----------------------------------------------------------------
// Port checker for the decoder's timing and decode outputs.
// ----------------------------------------------------------------
module itd_monitor (
    input logic       clock,
    input logic       nrst,
    input logic       ce,
    input logic       fetch_q,
    input logic [3:0] iclass_q,
    input logic [2:0] bitsel_q,
    input logic [7:0] bitmask_q,
    input logic       dest_file_q,
    input logic       rd_file_q,
    input logic       wr_file_q,
    input logic       wr_acc_q,
    input logic       nop_cycle_q,
    input logic       stall_cycle_q,
    input logic       reserved_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // A write-back must follow the read of the same cycle.
    chk_rmw_order: assert property (wr_file_q |-> $past(rd_file_q, 2))
        else $error("file write without earlier read");
    chk_acc_dest: assert property (wr_acc_q |-> !dest_file_q && !wr_file_q)
        else $error("accumulator write with file destination");
    chk_fetch_gap: assert property (fetch_q |=> !fetch_q [*3])
        else $error("fetch requests closer than four clocks");
    chk_bit_mask: assert property (iclass_q == `ITD_C_BIT |->
        bitmask_q == (8'h01 << bitsel_q)) else $error("bit mask not one-hot");
    chk_reserved_flag: assert property (reserved_q ==
        (iclass_q == `ITD_C_RSVD)) else $error("reserved flag disagrees");
    chk_stall_len: assert property ($rose(stall_cycle_q) |->
        stall_cycle_q [*4] ##1 !stall_cycle_q) else $error("stall length");
    chk_nop_len: assert property ($rose(nop_cycle_q) |->
        nop_cycle_q [*4] ##1 !nop_cycle_q) else $error("no-op length");
    // The last three clocks of a no-op cycle must not write the file register or the accumulator.
    chk_nop_quiet: assert property (nop_cycle_q && $past(nop_cycle_q) |->
        !wr_file_q && !wr_acc_q) else $error("write during no-op");
    chk_fetch_freeze: assert property (!ce |=> $stable(fetch_q))
        else $error("fetch while frozen");
endmodule

bind itd_top itd_monitor itd_monitor_inst (.clock(clock), .nrst(nrst),
    .ce(ce), .fetch_q(fetch_q), .iclass_q(iclass_q), .bitsel_q(bitsel_q),
    .bitmask_q(bitmask_q), .dest_file_q(dest_file_q), .rd_file_q(rd_file_q),
    .wr_file_q(wr_file_q), .wr_acc_q(wr_acc_q), .nop_cycle_q(nop_cycle_q),
    .stall_cycle_q(stall_cycle_q), .reserved_q(reserved_q));

/* File: sim/itd_pmem_model.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Program memory: answers each fetch request with the next word.
// ----------------------------------------------------------------
module itd_pmem_model (
    input  logic        clock,
    input  logic        nrst,
    input  logic        fetch_q,
    input  logic [13:0] word,
    output logic [13:0] instr,
    output logic        instr_valid
);
    // The image holds one word repeated, so steady state is timed.
    // Unused word bits are written as zero by the image builder.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            instr <= 14'h0000;
            instr_valid <= 1'b1;
        end else if (fetch_q) begin
            instr <= word;
        end
    end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`include "itd_consts.vh"

module tb_top;
    logic        clock, nrst, test_true, instr_valid, fetch_q;
    logic        dest_file_q, ptr_sel_q, ce, reserved_q;
    logic [3:0]  iclass_q;
    logic [1:0]  phase_q, ph_hold;
    logic [15:0] ptr0, ptr1;
    logic [13:0] word, instr, w;
    logic [6:0]  faddr_q;
    logic [2:0]  bitsel_q;
    logic [7:0]  bitmask_q;
    logic [1:0]  step_select_q;
    int          failures, samples_checked, gap, i;
    logic [16:0] cases [20] = '{17'h007a5, 17'h00725, 17'h08780, 17'h04781,
        17'h08781, 17'h02005, 17'h0000a, 17'h00008, 17'h00009, 17'h03412,
        17'h02805, 17'h03201, 17'h0000b, 17'h11d25, 17'h01d25, 17'h11525,
        17'h10ba5, 17'h00fa5, 17'h18b80, 17'h01525};

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    itd_top itd_top_inst (.clock(clock), .nrst(nrst), .ce(ce),
        .instr(instr), .instr_valid(instr_valid), .test_true(test_true),
        .ptr0(ptr0), .ptr1(ptr1), .fetch_q(fetch_q), .iclass_q(iclass_q),
        .faddr_q(faddr_q), .bitsel_q(bitsel_q), .bitmask_q(bitmask_q),
        .dest_file_q(dest_file_q), .rd_file_q(), .wr_file_q(), .wr_acc_q(),
        .ptr_sel_q(ptr_sel_q), .step_select_q(step_select_q),
        .nop_cycle_q(), .stall_cycle_q(), .reserved_q(reserved_q),
        .phase_q(phase_q));
    itd_pmem_model itd_pmem_model_inst (.clock(clock), .nrst(nrst),
        .fetch_q(fetch_q), .word(word), .instr(instr),
        .instr_valid(instr_valid));

    // Expected clocks per word: branches, returns and taken skips double,
    // an indirect access into program memory adds one cycle.
    function automatic int exp_clk(logic [13:0] v, logic tt, m0, m1);
        int c;
        c = 1;
        if (v[13:12] == 2'b10 || v[13:9] == 5'b11001 || v[13:8] == 6'h34 ||
            v inside {14'h0008, 14'h0009, 14'h000a, 14'h000b})
            c = 2;
        if (tt && (v[13:11] == 3'b011 || v[13:8] inside {6'h0b, 6'h0f}))
            c = 2;
        if ((v[13:12] == 2'b01 || v[13:12] == 2'b00 && v[11:8] != 4'h0)
            && v[6:1] == 6'h00 && (v[0] ? m1 : m0))
            c = c + 1;
        return 4 * c;
    endfunction

    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hold one word in memory and time the gap between fetches.
    task run(input logic [13:0] v, input logic tt, m0, m1);
        @(posedge clock);
        word <= v;
        test_true <= tt;
        ptr0 <= {m0, 15'($urandom)};
        ptr1 <= {m1, 15'($urandom)};
        repeat (4) begin
            @(negedge clock);
            gap = 1;
            while (!fetch_q && gap < 40) begin
                @(negedge clock);
                gap++;
            end
        end
        check(16'(gap), 16'(exp_clk(v, tt, m0, m1)));
    endtask

    task give_verdict;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        give_verdict;
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        word = 14'h0000;
        test_true = 1'b0;
        ptr0 = 16'h0000;
        ptr1 = 16'h0000;
        failures = 0;
        samples_checked = 0;
        void'($urandom(30));
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        foreach (cases[k])
            run(cases[k][13:0], cases[k][16], cases[k][15], cases[k][14]);
        // Every pointer pair and every step mode of the indirect moves.
        for (i = 0; i < 8; i++) begin
            run(14'h0010 | 14'(i), 1'b0, 1'b0, 1'b0);
            check(16'(ptr_sel_q), 16'(i >> 2));
            check(16'(step_select_q), 16'(i & 3));
            check(16'(iclass_q), 16'(`ITD_C_IND));
            check(16'(reserved_q), 16'h0000);
        end
        // Freeze the core: no fetch and no phase step until ce returns.
        @(posedge clock);
        ce <= 1'b0;
        @(negedge clock);
        ph_hold = phase_q;
        repeat (12) begin
            @(negedge clock);
            check(16'(fetch_q), 16'h0000);
            check(16'(phase_q), 16'(ph_hold));
        end
        @(posedge clock);
        ce <= 1'b1;
        // Random byte and bit operations on direct file addresses.
        for (i = 0; i < 24; i++) begin
            w = {i[0] ? 4'b0101 : 4'b0001, 3'($urandom), 7'($urandom % 126 + 2)};
            w[13:10] = i[0] ? 4'b0101 : 4'b0001;
            if (!i[0])
                w[9:8] = 2'b11;
            run(w, 1'($urandom), 1'($urandom), 1'($urandom));
            check(16'(faddr_q), 16'(w[6:0]));
            if (i[0]) begin
                check(16'(bitsel_q), 16'(w[9:7]));
                check(16'(bitmask_q), 16'(8'h01 << w[9:7]));
            end else begin
                check(16'(dest_file_q), 16'(w[7]));
            end
        end
        give_verdict;
    end
endmodule
